// ### hdl/uin_decoder.sv
`timescale 1ns/10ps
//Contract
//- Key held longer than 0,3 s is a long press.
//- Key released before the long threshold is a short press.
//- Prompt steady when more follows, blinking when probing resumes.
//- Encoder counts Gray transitions, one step per detent of set pulses.
//- Velocity scaled by detents per turn; more detents means slower.
//- Velocity timed over two consecutive steps.
//- Lone step lowest speed; mid needs two steps, highest three.
//- Increase and decrease buttons are active low, giving step events.
//- Held button beyond long time keeps raising the speed level.
//- Touch area split into 3-column side bars, 2-line top/bottom bars, centre.
//- Left/top touch steps down, right/bottom steps up, like encoder.
//- Sustained bar touch raises speed level.
//- Centre touch acts as test key but never drives hardware key line.
//- Calibration starts at power-up without stored values, or on request.
//- Capture top-right target first, then bottom-left, clearing each marker.
//- At most three calibration rounds; a key press aborts at once.
//- Touch origin top-left, with x-flip, y-flip and rotation applied.
//- Serial 9600 8N1; every sent line ends with CR then LF.
//- Commands taken only while waiting for user feedback.
//- Remote commands force auto-hold and stop automatic probing at power-up.
//- Special glyphs replaced by plain ASCII before sending.
module uin_decoder #(
  parameter int MS_CYC = uin_pkg::MS_CYC,
  parameter int BIT_CYC = uin_pkg::BIT_CYC,
  parameter int PULSES = uin_pkg::ENC_PULSES,
  parameter int STEPS = uin_pkg::ENC_STEPS,
  parameter int DBL_GAP = uin_pkg::DBL_GAP_MS,
  parameter int TW = 12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic key_n,
  input wire logic enc_a_n,
  input wire logic enc_b_n,
  input wire logic inc_n,
  input wire logic dec_n,
  input wire logic rxd,
  input wire logic touch_valid,
  input wire logic [TW-1:0] touch_x,
  input wire logic [TW-1:0] touch_y,
  input wire logic cal_stored,
  input wire logic await_feedback,
  input wire logic wait_key,
  input wire logic more_info,
  input wire logic hold_mode,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_eol,
  output logic tx_ready,
  output logic txd,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic key_short,
  output logic key_long,
  output logic key_double,
  output logic key_hw,
  output logic prompt_on,
  output logic step_inc,
  output logic step_dec,
  output logic [2:0] speed,
  output logic cal_active,
  output logic [1:0] cal_marker,
  output logic cal_ok,
  output logic cal_fail,
  output logic [7:0] cmd_char,
  output logic cmd_valid,
  output logic cmd_eol,
  output logic auto_hold,
  output logic auto_probe,
  output logic result_echo
);
  typedef struct packed {
    logic [16:0] mcnt;
    logic kact_q;
    logic [9:0] kcnt;
    logic klong;
    logic pend;
    logic [9:0] gap;
    logic ks;
    logic kl;
    logic kd;
    logic khw;
    logic [9:0] bcnt;
    logic blink;
    logic prompt;
    logic [1:0] ab;
    logic signed [3:0] pcnt;
    logic [9:0] tms;
    logic [9:0] tprev;
    logic [1:0] run;
    logic estep;
    logic sinc;
    logic sdec;
    logic [2:0] speed;
    logic hold_q;
    logic [9:0] hcnt;
    logic tch_q;
    uin_pkg::uin_zone_t tz;
    uin_pkg::uin_cal_t cal;
    logic [1:0] round;
    logic [TW-1:0] xtr;
    logic [TW-1:0] ytr;
    logic [TW-1:0] xbl;
    logic [TW-1:0] ybl;
    logic cvalid;
    logic cok;
    logic cfail;
    logic booted;
    logic [4:0] ctrl;
    logic ah;
    logic ap;
    uin_pkg::uin_rx_t rx;
    logic [13:0] rcnt;
    logic [2:0] rbit;
    logic [7:0] rsh;
    logic [7:0] cchar;
    logic cv;
    logic ceol;
    logic [9:0] tshn;
    logic [3:0] tbit;
    logic [13:0] tcnt;
    logic crp;
    logic lfp;
    logic [31:0] rdata;
  } uin_st_t;
  uin_st_t s;
  uin_st_t n;
  uin_pin_if #(.W(uin_pkg::NPIN)) pin();
  logic [TW-1:0] tx_r, ty_r, tx_t, ty_t, dx, dy, sx, sy;
  uin_pkg::uin_zone_t zone;

  uin_sync #(.W(uin_pkg::NPIN)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_n({rxd, dec_n, inc_n, enc_b_n, enc_a_n, key_n}),
    .o(pin)
  );

  // Orientation first, then bar bounds from the calibrated corners
  assign tx_r = s.ctrl[uin_pkg::C_ROT] ? touch_y : touch_x;
  assign ty_r = s.ctrl[uin_pkg::C_ROT] ? touch_x : touch_y;
  assign tx_t = s.ctrl[uin_pkg::C_FLX] ? ~tx_r : tx_r;
  assign ty_t = s.ctrl[uin_pkg::C_FLY] ? ~ty_r : ty_r;
  assign dx = s.xtr - s.xbl;
  assign dy = s.ybl - s.ytr;
  assign sx = (dx >> 3) + (dx >> 4); // 3 of 16 columns
  assign sy = dy >> 2; // 2 of 8 lines

  // Side bars win over top and bottom in the corners
  always_comb begin
    zone = uin_pkg::Z_CTR;
    if (!s.cvalid) zone = uin_pkg::Z_NONE;
    else if (tx_t < s.xbl + sx) zone = uin_pkg::Z_LEFT;
    else if (tx_t > s.xtr - sx) zone = uin_pkg::Z_RIGHT;
    else if (ty_t < s.ytr + sy) zone = uin_pkg::Z_TOP;
    else if (ty_t > s.ybl - sy) zone = uin_pkg::Z_BOT;
  end

  // Whole next state
  always_comb begin
    logic tick, kact, hinc, hdec, hold, cstart;
    logic [1:0] abn;
    logic signed [3:0] pn;
    logic [10:0] span;
    logic [1:0] rn;
    int prod;
    logic rxl;
    logic [7:0] txb;
    tick = s.mcnt == 17'(MS_CYC - 1);
    kact = 1'b0;
    hinc = 1'b0;
    hdec = 1'b0;
    hold = 1'b0;
    cstart = 1'b0;
    abn = {pin.lvl[uin_pkg::P_ENCA], pin.lvl[uin_pkg::P_ENCB]};
    pn = s.pcnt;
    span = 11'(s.tprev) + 11'(s.tms);
    rn = s.run;
    prod = 0;
    rxl = ~pin.lvl[uin_pkg::P_RXD];
    txb = tx_data;
    n = s;
    n.ks = 1'b0;
    n.kl = 1'b0;
    n.kd = 1'b0;
    n.estep = 1'b0;
    n.sinc = 1'b0;
    n.sdec = 1'b0;
    n.cok = 1'b0;
    n.cfail = 1'b0;
    n.cv = 1'b0;
    n.ceol = 1'b0;
    n.mcnt = tick ? 17'h00000 : s.mcnt + 17'h00001;

    // Test key: physical key or centre touch, timed in ms ticks
    kact = pin.lvl[uin_pkg::P_KEY] | (s.tch_q & touch_valid & (s.tz == uin_pkg::Z_CTR));
    n.kact_q = kact;
    n.khw = pin.lvl[uin_pkg::P_KEY];
    if (kact && !s.kact_q) begin
      n.kcnt = 10'h000;
      n.klong = 1'b0;
    end else if (kact && tick && s.kcnt != uin_pkg::LONG_MS) begin
      n.kcnt = s.kcnt + 10'h001;
    end
    // A lone short waits out the gap, costing latency to tell it from a double
    if (s.pend && tick) begin
      if (s.gap == 10'(DBL_GAP - 1)) begin
        n.ks = 1'b1;
        n.pend = 1'b0;
      end else begin
        n.gap = s.gap + 10'h001;
      end
    end
    if (!kact && s.kact_q && !s.klong) begin
      if (s.pend && !n.ks) begin
        n.kd = 1'b1;
        n.pend = 1'b0;
      end else begin
        n.pend = 1'b1;
        n.gap = 10'h000;
      end
    end
    if (kact && s.kcnt == uin_pkg::LONG_MS && !s.klong) begin
      n.klong = 1'b1;
      n.kl = 1'b1;
      n.ks = s.pend | n.ks;
      n.pend = 1'b0;
    end

    // Prompt: steady when more follows, blinking before probing resumes
    if (tick) begin
      n.bcnt = (s.bcnt == uin_pkg::BLINK_MS - 10'h001) ? 10'h000 : s.bcnt + 10'h001;
      if (s.bcnt == uin_pkg::BLINK_MS - 10'h001) n.blink = ~s.blink;
    end
    n.prompt = wait_key & (more_info | s.blink);

    // Encoder: single-bit Gray changes only; a double jump is noise
    n.ab = abn;
    if (tick && s.tms != uin_pkg::VEL_IDLE_MS) n.tms = s.tms + 10'h001;
    if (^{abn, s.ab}) begin
      pn = (s.ab[1] ^ abn[0]) ? s.pcnt + 4'sh1 : s.pcnt - 4'sh1;
      n.pcnt = pn;
      if (pn == 4'(PULSES) || pn == 4'(-PULSES)) begin
        n.pcnt = 4'sh0;
        n.estep = 1'b1;
        n.sinc = pn == 4'(PULSES);
        n.sdec = pn != 4'(PULSES);
        rn = (s.tms == uin_pkg::VEL_IDLE_MS) ? 2'h1 : ((s.run == 2'h3) ? 2'h3 : s.run + 2'h1);
        n.run = rn;
        prod = int'(span) * STEPS;
        if (rn == 2'h3 && prod < uin_pkg::VEL_HI_LIM) n.speed = 3'h3;
        else if (rn >= 2'h2 && prod < uin_pkg::VEL_MID_LIM) n.speed = 3'h2;
        else n.speed = 3'h1;
        n.tprev = s.tms;
        n.tms = 10'h000;
      end
    end

    // Buttons and touch bars share one hold-to-repeat engine
    hinc = pin.lvl[uin_pkg::P_INC] | (s.tch_q & touch_valid & ((s.tz == uin_pkg::Z_RIGHT) |
           (s.tz == uin_pkg::Z_BOT)));
    hdec = pin.lvl[uin_pkg::P_DEC] | (s.tch_q & touch_valid & ((s.tz == uin_pkg::Z_LEFT) |
           (s.tz == uin_pkg::Z_TOP)));
    hold = hinc | hdec;
    n.hold_q = hold;
    if (hold && !s.hold_q) begin
      n.sinc = hinc;
      n.sdec = hdec & ~hinc;
      n.speed = 3'h1;
      n.hcnt = 10'h000;
    end else if (hold && tick) begin
      if (s.hcnt == uin_pkg::LONG_MS - 10'h001) begin
        n.hcnt = 10'h000;
        n.speed = (s.speed == uin_pkg::SPEED_MAX) ? s.speed : s.speed + 3'h1;
        n.sinc = hinc;
        n.sdec = hdec & ~hinc;
      end else begin
        n.hcnt = s.hcnt + 10'h001;
      end
    end

    // Touch zone latched at first contact; calibration owns the panel meanwhile
    n.tch_q = touch_valid & (s.cal == uin_pkg::CAL_IDLE);
    if (touch_valid && !s.tch_q) n.tz = zone;

    // Calibration sequence
    n.booted = 1'b1;
    if (!s.booted && !cal_stored) cstart = 1'b1;
    if (wr && addr == uin_pkg::REG_CTRL && wdata[uin_pkg::C_CAL]) cstart = 1'b1;
    case (s.cal)
      uin_pkg::CAL_IDLE: begin
      end
      uin_pkg::CAL_TR: begin
        if (touch_valid) begin
          n.xtr = tx_t;
          n.ytr = ty_t;
          n.cal = uin_pkg::CAL_TR_REL;
        end
      end
      uin_pkg::CAL_TR_REL: begin
        if (!touch_valid) n.cal = uin_pkg::CAL_BL;
      end
      uin_pkg::CAL_BL: begin
        if (touch_valid) begin
          n.xbl = tx_t;
          n.ybl = ty_t;
          n.cal = uin_pkg::CAL_BL_REL;
        end
      end
      uin_pkg::CAL_BL_REL: begin
        if (!touch_valid) n.cal = uin_pkg::CAL_CHK;
      end
      uin_pkg::CAL_CHK: begin
        if (int'(s.xtr) > int'(s.xbl) + uin_pkg::CAL_MARGIN && int'(s.ybl) > int'(s.ytr) + uin_pkg::CAL_MARGIN) begin
          n.cvalid = 1'b1;
          n.cok = 1'b1;
          n.cal = uin_pkg::CAL_IDLE;
        end else if (s.round == uin_pkg::CAL_ROUNDS - 2'h1) begin
          n.cfail = 1'b1;
          n.cal = uin_pkg::CAL_IDLE;
        end else begin
          n.round = s.round + 2'h1;
          n.cal = uin_pkg::CAL_TR;
        end
      end
      default: n.cal = uin_pkg::CAL_IDLE;
    endcase
    if (cstart) begin
      n.cal = uin_pkg::CAL_TR;
      n.round = 2'h0;
      n.cvalid = 1'b0;
    end
    if (pin.prs[uin_pkg::P_KEY] && (s.cal != uin_pkg::CAL_IDLE || cstart)) n.cal = uin_pkg::CAL_IDLE;

    // Register port; reads answer in the next cycle only
    if (wr && addr == uin_pkg::REG_CTRL) n.ctrl = wdata[4:0];
    n.ah = s.ctrl[uin_pkg::C_RCE] | hold_mode;
    n.ap = ~s.ctrl[uin_pkg::C_RCE];
    n.rdata = 32'h00000000;
    if (rd) begin
      case (addr)
        uin_pkg::REG_CTRL: n.rdata = {27'h0000000, s.ctrl};
        uin_pkg::REG_STAT: n.rdata = {24'h000000, s.cvalid, s.round, s.speed, s.cal != uin_pkg::CAL_IDLE, s.prompt};
        uin_pkg::REG_CALX: n.rdata = {16'(s.xtr), 16'(s.xbl)};
        uin_pkg::REG_CALY: n.rdata = {16'(s.ytr), 16'(s.ybl)};
        default: n.rdata = 32'h00000000;
      endcase
    end

    // Receiver: sample mid-bit; CR dropped so CR LF and lone LF both end a line
    case (s.rx)
      uin_pkg::RX_IDLE: begin
        if (!rxl) begin
          n.rx = uin_pkg::RX_START;
          n.rcnt = 14'(BIT_CYC / 2);
        end
      end
      uin_pkg::RX_START: begin
        if (s.rcnt != 14'h0000) n.rcnt = s.rcnt - 14'h0001;
        else if (rxl) n.rx = uin_pkg::RX_IDLE;
        else begin
          n.rx = uin_pkg::RX_DATA;
          n.rcnt = 14'(BIT_CYC - 1);
          n.rbit = 3'h0;
        end
      end
      uin_pkg::RX_DATA: begin
        if (s.rcnt != 14'h0000) n.rcnt = s.rcnt - 14'h0001;
        else begin
          n.rsh = {rxl, s.rsh[7:1]};
          n.rcnt = 14'(BIT_CYC - 1);
          n.rbit = s.rbit + 3'h1;
          if (s.rbit == 3'h7) n.rx = uin_pkg::RX_STOP;
        end
      end
      uin_pkg::RX_STOP: begin
        if (s.rcnt != 14'h0000) n.rcnt = s.rcnt - 14'h0001;
        else begin
          n.rx = uin_pkg::RX_IDLE;
          if (rxl && s.ctrl[uin_pkg::C_RCE] && await_feedback) begin
            n.ceol = s.rsh == uin_pkg::CH_LF;
            n.cv = s.rsh != uin_pkg::CH_LF && s.rsh != uin_pkg::CH_CR;
            n.cchar = s.rsh;
          end
        end
      end
      default: n.rx = uin_pkg::RX_IDLE;
    endcase

    // Transmitter: inverted shifter so reset leaves the line idle high
    if (tx_data == uin_pkg::GLY_OHM) txb = uin_pkg::CH_R;
    else if (tx_data == uin_pkg::GLY_MICRO) txb = uin_pkg::CH_U;
    if (s.tbit != 4'h0) begin
      if (s.tcnt != 14'h0000) n.tcnt = s.tcnt - 14'h0001;
      else begin
        n.tshn = {1'b0, s.tshn[9:1]};
        n.tcnt = 14'(BIT_CYC - 1);
        n.tbit = s.tbit - 4'h1;
      end
    end else if (s.crp || s.lfp) begin
      n.tshn = ~{1'b1, s.crp ? uin_pkg::CH_CR : uin_pkg::CH_LF, 1'b0};
      n.crp = 1'b0;
      n.lfp = s.crp;
      n.tbit = 4'hA;
      n.tcnt = 14'(BIT_CYC - 1);
    end else begin
      if (tx_valid) begin
        n.tshn = ~{1'b1, txb, 1'b0};
        n.tbit = 4'hA;
        n.tcnt = 14'(BIT_CYC - 1);
      end
      if (tx_eol) begin
        n.crp = 1'b1;
        n.lfp = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Outputs
  assign tx_ready = (s.tbit == 4'h0) & ~s.crp & ~s.lfp;
  assign txd = ~s.tshn[0];
  assign rdata = s.rdata;
  assign key_short = s.ks;
  assign key_long = s.kl;
  assign key_double = s.kd;
  assign key_hw = s.khw;
  assign prompt_on = s.prompt;
  assign step_inc = s.sinc;
  assign step_dec = s.sdec;
  assign speed = s.speed;
  assign cal_active = s.cal != uin_pkg::CAL_IDLE;
  assign cal_marker = {s.cal == uin_pkg::CAL_BL, s.cal == uin_pkg::CAL_TR};
  assign cal_ok = s.cok;
  assign cal_fail = s.cfail;
  assign cmd_char = s.cchar;
  assign cmd_valid = s.cv;
  assign cmd_eol = s.ceol;
  assign auto_hold = s.ah;
  assign auto_probe = s.ap;
  assign result_echo = s.ctrl[uin_pkg::C_ECHO];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence q_tr_touch;
    s.cal == uin_pkg::CAL_TR && touch_valid && !pin.prs[uin_pkg::P_KEY];
  endsequence
  sequence q_tr_taken;
    ##1 (s.cal == uin_pkg::CAL_TR_REL && cal_marker == 2'h0 && s.xtr == $past(tx_t));
  endsequence
  property p_long;
    key_long |-> s.klong && s.kcnt == uin_pkg::LONG_MS;
  endproperty
  a_long: assert property (p_long) else $error("long press without full hold");
  property p_short;
    key_short |-> $past(s.pend) && !s.pend;
  endproperty
  a_short: assert property (p_short) else $error("short press without pending release");
  property p_double;
    key_double |-> $past(s.pend) && !key_short && !s.pend;
  endproperty
  a_double: assert property (p_double) else $error("double press without first short");
  property p_prompt;
    !wait_key |=> !prompt_on;
  endproperty
  a_prompt: assert property (p_prompt) else $error("prompt shown while not waiting");
  property p_detent;
    s.estep |-> s.pcnt == 4'sh0 && ($past(s.pcnt) == 4'(PULSES - 1) || $past(s.pcnt) == 4'(1 - PULSES));
  endproperty
  a_detent: assert property (p_detent) else $error("step not on detent count");
  property p_vel;
    s.estep && !s.hold_q |-> (s.speed != 3'h3 || s.run == 2'h3) && (s.speed == 3'h1 || s.run >= 2'h2);
  endproperty
  a_vel: assert property (p_vel) else $error("speed above step history");
  property p_hw;
    !pin.lvl[uin_pkg::P_KEY] |=> !key_hw;
  endproperty
  a_hw: assert property (p_hw) else $error("key line driven without key");
  property p_cal_tr;
    q_tr_touch |-> q_tr_taken;
  endproperty
  a_cal_tr: assert property (p_cal_tr) else $error("top-right capture missed");
  property p_abort;
    pin.prs[uin_pkg::P_KEY] |=> !cal_active;
  endproperty
  a_abort: assert property (p_abort) else $error("calibration not aborted");
  property p_cmd;
    cmd_valid || cmd_eol |-> $past(s.ctrl[uin_pkg::C_RCE] && await_feedback);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command taken outside window");
  property p_auto;
    s.ctrl[uin_pkg::C_RCE] |=> auto_hold && !auto_probe;
  endproperty
  a_auto: assert property (p_auto) else $error("remote mode without auto-hold");
endmodule // uin_decoder

// ### hdl/uin_pkg.sv
package uin_pkg;
  // Time base: a 1 ms enable pulse drives all human-scale timing
  localparam int CLK_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam int BAUD = 9600;
  localparam int BIT_CYC = 1000000000 / (BAUD * CLK_NS);
  localparam logic [9:0] LONG_MS = 10'h12C; // 300 ms
  localparam int DBL_GAP_MS = 250;
  localparam logic [9:0] BLINK_MS = 10'h1F4;
  // Encoder defaults
  localparam int ENC_PULSES = 4;
  localparam int ENC_STEPS = 24;
  localparam logic [9:0] VEL_IDLE_MS = 10'h1F4;
  localparam int VEL_MID_LIM = 2400;
  localparam int VEL_HI_LIM = 960;
  localparam logic [2:0] SPEED_MAX = 3'h7;
  // Calibration
  localparam logic [1:0] CAL_ROUNDS = 2'h3;
  localparam int CAL_MARGIN = 64;
  // Synchronised pin indexes
  localparam int NPIN = 6;
  localparam int P_KEY = 0;
  localparam int P_ENCA = 1;
  localparam int P_ENCB = 2;
  localparam int P_INC = 3;
  localparam int P_DEC = 4;
  localparam int P_RXD = 5;
  // Register map and control bits
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CALX = 8'h08;
  localparam logic [7:0] REG_CALY = 8'h0C;
  localparam int C_RCE = 0;
  localparam int C_ECHO = 1;
  localparam int C_FLX = 2;
  localparam int C_FLY = 3;
  localparam int C_ROT = 4;
  localparam int C_CAL = 5;
  // Characters
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] GLY_OHM = 8'hF4;
  localparam logic [7:0] GLY_MICRO = 8'hE4;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_U = 8'h75;
  typedef enum logic [2:0] {CAL_IDLE, CAL_TR, CAL_TR_REL, CAL_BL, CAL_BL_REL, CAL_CHK} uin_cal_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uin_rx_t;
  typedef enum logic [2:0] {Z_NONE, Z_LEFT, Z_RIGHT, Z_TOP, Z_BOT, Z_CTR} uin_zone_t;
endpackage

// ### hdl/uin_pin_if.sv
`timescale 1ns/10ps
// Synchronised pin levels (active high) and press pulses
interface uin_pin_if #(parameter int W = 6);
  logic [W-1:0] lvl;
  logic [W-1:0] prs;
  modport src(output lvl, output prs);
  modport snk(input lvl, input prs);
endinterface

// ### hdl/uin_sync.sv
`timescale 1ns/10ps
module uin_sync #(parameter int W = 6) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_n,
  uin_pin_if.src o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } uin_sy_t;
  uin_sy_t s;
  uin_sy_t n;

  // Pins are active low; invert before the first stage, which only the second stage reads
  always_comb begin
    n.s1 = ~pin_n;
    n.s2 = s.s1;
    n.s3 = s.s2;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // No debounce: slow human timing is taken from the 1 ms tick downstream
  assign o.lvl = s.s2;
  assign o.prs = s.s2 & ~s.s3;
endmodule // uin_sync

// ### tb/uin_partner.sv
`timescale 1ns/10ps
// Operator pins and PC terminal; every pin idles high as if pulled up
module uin_partner #(parameter int BC = 8) (
  input wire logic clk,
  input wire logic txd,
  output logic key_n,
  output logic enc_a_n,
  output logic enc_b_n,
  output logic inc_n,
  output logic dec_n,
  output logic rxd
);
  // Released pins rest high, so idle never reads as a press
  initial begin
    {key_n, enc_a_n, enc_b_n, inc_n, dec_n, rxd} = 6'h3F;
  end
  // One 8N1 frame, LSB first
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BC) @(posedge clk);
    end
  endtask
  // Mid-bit sampling; ok needs a start bit in time and a high stop bit
  task automatic recv(output logic [7:0] c, output logic ok);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (BC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge clk);
      c[i] = txd;
    end
    repeat (BC) @(posedge clk);
    ok = (n < 200) && (txd === 1'b1);
  endtask
endmodule // uin_partner

// ### tb/uin_decoder_test.sv
`timescale 1ns/10ps
module uin_decoder_test;
  localparam int BC = 8;
  logic clk, sys_rst, key_n, enc_a_n, enc_b_n, inc_n, dec_n, rxd, touch_valid, cal_stored, await_feedback;
  logic wait_key, more_info, hold_mode, tx_valid, tx_eol, tx_ready, txd, wr, rd, key_short, key_long;
  logic key_double, key_hw, prompt_on, step_inc, step_dec, cal_active, cal_ok, cal_fail, cmd_valid, cmd_eol;
  logic auto_hold, auto_probe, result_echo, ok;
  logic [11:0] touch_x, touch_y;
  logic [7:0] tx_data, addr, cmd_char, last_cmd, b;
  logic [31:0] wdata, rdata, d;
  logic [2:0] speed;
  logic [1:0] cal_marker;
  logic [7:0] tx_exp [6] = '{uin_pkg::CH_R, uin_pkg::CH_CR, uin_pkg::CH_LF, uin_pkg::CH_U, uin_pkg::CH_CR,
    uin_pkg::CH_LF};
  int fails, total_checks, n_sh, n_lg, n_db, n_inc, n_dec, n_val, n_eol;
  // Short ms tick and bit time keep the run brief
  uin_decoder #(.MS_CYC(10), .BIT_CYC(BC)) u_uin_decoder (.*);
  uin_partner #(.BC(BC)) u_uin_partner (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Event pulses last one cycle, so tally them on every edge
  always @(posedge clk) begin
    if (key_short === 1'b1) n_sh++;
    if (key_long === 1'b1) n_lg++;
    if (key_double === 1'b1) n_db++;
    if (step_inc === 1'b1) n_inc++;
    if (step_dec === 1'b1) n_dec++;
    if (cmd_eol === 1'b1) n_eol++;
    if (cmd_valid === 1'b1) begin
      n_val++;
      last_cmd <= cmd_char;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ms(input int n);
    repeat (n * 10) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic key(input int n);
    u_uin_partner.key_n <= 1'b0;
    ms(n);
    chk(key_hw, 32'h1);
    u_uin_partner.key_n <= 1'b1;
    ms(60);
  endtask
  // Four Gray transitions make one detent
  task automatic turn(input bit cw);
    logic [1:0] j;
    for (int i = 1; i < 5; i++) begin
      j = cw ? 2'(i) : 2'(4 - i);
      u_uin_partner.enc_a_n <= ~j[1];
      u_uin_partner.enc_b_n <= ~(j[1] ^ j[0]);
      repeat (6) @(posedge clk);
    end
  endtask
  // One touch of n ms at a raw position, then lift; the hardware key line must be low just before the lift
  task automatic tap(input logic [11:0] x, input logic [11:0] y, input int n);
    touch_x <= x;
    touch_y <= y;
    touch_valid <= 1'b1;
    ms(n);
    chk(key_hw, 32'h0);
    touch_valid <= 1'b0;
    ms(2);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {touch_valid, await_feedback, wait_key, more_info, hold_mode, tx_valid, tx_eol, wr, rd} = '0;
    cal_stored = 1'b1;
    {touch_x, touch_y, tx_data, addr, wdata} = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(auto_probe, 32'h1);
    wr_reg(uin_pkg::REG_CTRL, 32'h3);
    rd_reg(uin_pkg::REG_CTRL, d);
    chk(d, 32'h3);
    chk({auto_hold, result_echo}, 32'h3);
    rd_reg(8'h10, d);
    chk(d, 32'h0);
    key(320);
    ms(300);
    chk(n_lg, 32'h1);
    chk(n_sh, 32'h0);
    key(50);
    ms(300);
    chk(n_sh, 32'h1);
    key(50);
    key(50);
    ms(300);
    chk(n_db, 32'h1);
    chk(n_sh, 32'h1);
    turn(1'b1);
    ms(5);
    chk(n_inc, 32'h1);
    chk(speed, 32'h1);
    turn(1'b0);
    ms(5);
    chk(n_dec, 32'h1);
    // Third quick detent in a row reaches the top encoder speed
    turn(1'b1);
    ms(5);
    chk(speed, 32'h3);
    chk(n_inc, 32'h2);
    u_uin_partner.inc_n <= 1'b0;
    ms(50);
    u_uin_partner.inc_n <= 1'b1;
    ms(60);
    chk(n_inc, 32'h3);
    u_uin_partner.dec_n <= 1'b0;
    ms(700);
    chk(n_dec, 32'h4);
    chk(speed, 32'h3);
    u_uin_partner.dec_n <= 1'b1;
    wait_key <= 1'b1;
    more_info <= 1'b1;
    ms(5);
    chk(prompt_on, 32'h1);
    ms(600);
    chk(prompt_on, 32'h1);
    // Blinking prompt flips exactly once in any window of one blink period
    more_info <= 1'b0;
    ms(5);
    #1 d[0] = prompt_on;
    ms(500);
    #1 chk(prompt_on, !d[0]);
    // Each glyph goes out replaced and followed by a line end
    for (int k = 0; k < 2; k++) begin
      repeat (2 * BC) @(posedge clk);
      tx_data <= k ? uin_pkg::GLY_MICRO : uin_pkg::GLY_OHM;
      tx_valid <= 1'b1;
      tx_eol <= 1'b1;
      @(posedge clk);
      tx_valid <= 1'b0;
      tx_eol <= 1'b0;
      for (int m = 0; m < 3; m++) begin
        u_uin_partner.recv(b, ok);
        chk({ok, b}, {1'b1, tx_exp[3 * k + m]});
      end
    end
    await_feedback <= 1'b1;
    u_uin_partner.send(8'h41);
    repeat (BC) @(posedge clk);
    chk(n_val, 32'h1);
    chk(last_cmd, 32'h41);
    u_uin_partner.send(uin_pkg::CH_CR);
    u_uin_partner.send(uin_pkg::CH_LF);
    repeat (BC) @(posedge clk);
    chk(n_eol, 32'h1);
    await_feedback <= 1'b0;
    d = n_val;
    u_uin_partner.send(8'h42);
    repeat (BC) @(posedge clk);
    chk(n_val, d);
    // Key aborts a requested calibration; then calibrate and use the bars
    wr_reg(uin_pkg::REG_CTRL, 32'h23);
    ms(1);
    chk(cal_active, 32'h1);
    key(50);
    chk(cal_active, 32'h0);
    ms(250);
    wr_reg(uin_pkg::REG_CTRL, 32'h23);
    ms(1);
    chk(cal_marker, 32'h1);
    tap(12'hF00, 12'h100, 1);
    chk(cal_marker, 32'h2);
    tap(12'h100, 12'hF00, 1);
    rd_reg(uin_pkg::REG_CALX, d);
    chk(d, 32'h0F000100);
    rd_reg(uin_pkg::REG_STAT, d);
    chk({d[7], d[1]}, 32'h2);
    tap(12'h800, 12'h100, 50);
    chk(n_dec, 32'h5);
    tap(12'hF00, 12'h800, 350);
    chk(n_inc, 32'h5);
    chk(speed, 32'h2);
    tap(12'h800, 12'h800, 50);
    ms(300);
    chk(n_sh, 32'h3);
    end_sim();
  end
  // Run needs about 48000 cycles
  initial begin
    repeat (70000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule // uin_decoder_test
